// ==== pkg/rfc_pkg.sv ====
// Purpose: Shared constants for the receive framer control block
// Assumes: Register index n sits at byte address 4*n
// Notes: Mode-dependent registers share one stored byte per index
package rfc_pkg;
  // Register indices
  localparam logic [7:0] IDX_MASTER = 8'h80;
  localparam logic [7:0] IDX_CTRL1 = 8'h81;
  localparam logic [7:0] IDX_CTRL2 = 8'h82;
  localparam logic [7:0] IDX_CTRL3 = 8'h83;
  localparam logic [7:0] IDX_SA6 = 8'h6f;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Stored and readable bits
  localparam logic [7:0] MASK_MASTER = 8'hc3;
  localparam logic [7:0] MASK_CTRL1_E1 = 8'h7f;
  localparam logic [7:0] MASK_CTRL2_T1 = 8'h3f;
  localparam logic [7:0] MASK_CTRL2_E1 = 8'hf9;
  localparam logic [7:0] MASK_CTRL3 = 8'h80;
  // Master mode fields
  localparam int MM_FRAMER_ENABLE_BIT = 7;
  localparam int MM_INIT = 6;
  localparam int MM_SRST = 1;
  localparam int MM_E1 = 0;
  // Control one fields
  localparam int C1_SYNC_QUALIFY_LENGTH = 7;
  localparam int C1_ZSUB = 6;
  localparam int C1_FMT = 5;
  localparam int C1_ARC = 4;
  localparam int C1_SRCH = 3;
  localparam int C1_JCRC = 2;
  localparam int C1_NOAUTO = 1;
  localparam int C1_REALIGN = 0;
  localparam int C1_SIGM = 5;
  localparam int C1_TS26 = 4;
  localparam int C1_CRC4 = 3;
  localparam int C1_FRC = 2;
  // Control two and three fields
  localparam int C2_UP_LSB = 3;
  localparam int C2_DN_LSB = 0;
  localparam int C2_SA_LSB = 3;
  localparam int C2_LOSA = 0;
  localparam int C3_IDF = 7;
  // Line timing figures
  localparam logic [4:0] SYNC_QUAL_SHORT = 5'h0a;
  localparam logic [4:0] SYNC_QUAL_LONG = 5'h18;
  localparam logic [11:0] LOS_ZEROS_SHORT = 12'h0ff;
  localparam logic [11:0] LOS_ZEROS_LONG = 12'h800;
  localparam logic [1:0] FAS_ERR_LAST = 2'h2;
  localparam logic [4:0] TS_G802 = 5'h1a;
  localparam logic [4:0] TS_ALIGN = 5'h00;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] SA_FIRST_BIT = 3'h3;
  localparam logic [2:0] SA6_BIT = 3'h5;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [3:0] fn_code_len(input logic [2:0] code);
    return {1'b0, code} + 4'h1;
  endfunction
endpackage

// ==== pkg/rfc_line_if.sv ====
// Purpose: Carrier between control core and line monitor
// Assumes: Both ends on clk_i
// Notes: bitpos 0..7 stands for bits 1..8 of a time slot
`timescale 1ns/1ps
`default_nettype none
interface rfc_line_if;
  logic live;
  logic bit_en;
  logic pos;
  logic neg;
  logic nrz;
  logic e1;
  logic los_long;
  logic nfas;
  logic [4:0] ts;
  logic [2:0] bitpos;
  logic [4:0] sa_sel;
  logic los;
  logic data;
  logic data_en;
  logic spare_clk;
  logic [3:0] sa6_pat;
  modport ctl(output live, bit_en, pos, neg, nrz, e1, los_long, nfas, ts, bitpos, sa_sel,
              input los, data, data_en, spare_clk, sa6_pat);
  modport mon(input live, bit_en, pos, neg, nrz, e1, los_long, nfas, ts, bitpos, sa_sel,
              output los, data, data_en, spare_clk, sa6_pat);
endinterface
`default_nettype wire

// ==== hw/rfc_line_mon.sv ====
// Purpose: Zero run loss-of-signal monitor, Sa6 capture, spare-bit clock
// Assumes: bit_en is a one-cycle pulse per received bit
// Notes: Sa6 is grouped in fours with no submultiframe alignment
`timescale 1ns/1ps
`default_nettype none
module rfc_line_mon
  import rfc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Line side
  rfc_line_if.mon line
);
  typedef struct packed {
    logic [11:0] zeros;
    logic los;
    logic [3:0] sa6_sh;
    logic [1:0] sa6_n;
    logic [3:0] sa6_pat;
    logic spare;
    logic data;
    logic data_en;
  } rfc_mon_s;
  rfc_mon_s q, n;
  logic mark;
  logic in_ts0;
  logic [11:0] limit;

  assign mark = line.nrz ? line.pos : (line.pos | line.neg); // [RULE_24]
  assign limit = line.los_long ? LOS_ZEROS_LONG : LOS_ZEROS_SHORT; // [RULE_23]
  assign in_ts0 = line.e1 & line.nfas & (line.ts == TS_ALIGN);

  always_comb begin
    n = q;
    n.data_en = line.bit_en;
    // Registered, so the spare clock trails the slot position by one cycle
    n.spare = in_ts0 && (line.bitpos >= SA_FIRST_BIT) ?
              line.sa_sel[line.bitpos - SA_FIRST_BIT] : 1'b0; // [RULE_22]
    if (!line.live) begin
      n.zeros = '0;
      n.los = 1'b0;
      n.sa6_n = '0;
    end else if (line.bit_en) begin
      n.data = mark;
      if (mark) begin
        n.zeros = '0;
        n.los = 1'b0;
      end else if (q.zeros < limit) begin
        n.zeros = q.zeros + 12'h001;
      end
      if (n.zeros >= limit) begin
        n.los = 1'b1; // [RULE_23]
      end
      if (in_ts0 && line.bitpos == SA6_BIT) begin
        n.sa6_sh = {q.sa6_sh[2:0], mark};
        n.sa6_n = q.sa6_n + 2'h1;
        if (q.sa6_n == 2'h3) begin
          n.sa6_pat = n.sa6_sh; // [RULE_01]
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign line.los = q.los;
  assign line.data = q.data;
  assign line.data_en = q.data_en;
  assign line.spare_clk = q.spare;
  assign line.sa6_pat = q.sa6_pat;

  property p_los_count;
    @(posedge clk_i) disable iff (rst_i)
    $rose(q.los) |-> (q.zeros == 12'h0ff || q.zeros == 12'h800);
  endproperty
  a_los_count: assert property (p_los_count) else $error("loss of signal at wrong zero count"); // [RULE_23]

  property p_nrz_neg;
    @(posedge clk_i) disable iff (rst_i)
    line.live && line.bit_en && line.nrz && !line.pos |=> !q.data;
  endproperty
  a_nrz_neg: assert property (p_nrz_neg) else $error("negative input seen in NRZ mode"); // [RULE_24]

  c_los: cover property (@(posedge clk_i) disable iff (rst_i) $rose(q.los));
endmodule // rfc_line_mon
`default_nettype wire

// ==== hw/rfc_rx_framer_ctl.sv ====
// Purpose: Receive framer configuration, control and line monitor for one port
// Assumes: AXI4-Lite master with at most one write and one read in flight
// Notes: Register index n sits at byte address 4*n; line pins are asynchronous
//
// What this block does
// RULE_01 - Report last four received Sa6 bits
// RULE_02 - Software maps Sa6 patterns to codewords
// RULE_03 - Enable bit low holds framer idle
// RULE_04 - Host sets enable, standard before completion
// RULE_05 - Host writes every register before completion
// RULE_06 - Completion with enable set starts framer
// RULE_07 - Soft reset holds receiver while high
// RULE_08 - Standard select: 0 T1, 1 E1
// RULE_09 - T1 sync qualifies 10 or 24 bits
// RULE_10 - Zero substitution decode enable, B8ZS or HDB3
// RULE_11 - T1 format: 0 ESF, 1 D4
// RULE_12 - T1 resync on OOF and LOS, or OOF
// RULE_13 - T1 sync search criterion per format
// RULE_14 - T1 CRC-6 standard or Japanese
// RULE_15 - Auto resync disable blocks automatic resync
// RULE_16 - Realign bit rising edge starts resync
// RULE_17 - E1 signaling: 0 CAS, 1 CCS
// RULE_18 - E1 force channel block, slot 26 bit 1
// RULE_19 - E1 CRC-4 processing on or off
// RULE_20 - E1 three consecutive word errors force resync
// RULE_21 - T1 loop code lengths 1 to 7, 8/16
// RULE_22 - E1 Sa selects gate spare-bit clock
// RULE_23 - E1 LOS after 255 or 2048 zeros
// RULE_24 - NRZ input ignores negative, no BPV count
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module rfc_rx_framer_ctl
  import rfc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Line pins
  input wire logic rx_line_clk_i,
  input wire logic receive_line_positive_i,
  input wire logic receive_line_negative_i,
  // Framer core position and checks
  input wire logic [4:0] rx_timeslot_i,
  input wire logic [2:0] rx_bitpos_i,
  input wire logic rx_nfas_frame_i,
  input wire logic t1_oof_i,
  input wire logic fas_check_i,
  input wire logic fas_ok_i,
  input wire logic nfas_check_i,
  input wire logic nfas_bit2_ok_i,
  input wire logic channel_block_i,
  // Control to framer core
  output logic framer_active_o,
  output logic receiver_reset_o,
  output logic resync_o,
  output logic e1_mode_o,
  output logic [4:0] t1_sync_qual_bits_o,
  output logic t1_zero_subst_decode_o,
  output logic e1_zero_subst_decode_o,
  output logic t1_d4_framing_o,
  output logic t1_resync_oof_only_o,
  output logic t1_d4_cross_couple_o,
  output logic t1_esf_crc_verify_o,
  output logic t1_japanese_crc_o,
  output logic e1_ccs_signaling_o,
  output logic e1_checksum_enable_o,
  output logic [3:0] loop_up_len_o,
  output logic [3:0] loop_down_len_o,
  // Line status and data
  output logic los_o,
  output logic bpv_count_enable_o,
  output logic line_bit_o,
  output logic line_bit_en_o,
  output logic receive_spare_bit_clock_o,
  output logic receive_channel_block_o
);
  // Upper-bit decode needs at least one bit above the register window
  if (ADDR_W < 11 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must cover index 0x83");
  end

  typedef struct packed {
    logic [7:0] mmode;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] ctl3;
    logic init_prev;
    logic run;
    logic realign_prev;
    logic resync;
    logic oof_prev;
    logic los_prev;
    logic [1:0] fas_errs;
    logic e1_oof;
    logic [2:0] lclk_s;
    logic [1:0] pos_s;
    logic [1:0] neg_s;
    logic aw_hold;
    logic aw_ok;
    logic [7:0] aw_idx;
    logic w_hold;
    logic w_en;
    logic [7:0] w_byte;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rbyte;
    logic [1:0] rresp;
  } rfc_top_s;

  rfc_top_s q, n;
  rfc_line_if line ();
  logic e1, live, aw_go, w_go, ar_go, ar_ok, oof_ev, los_ev, manual, wr_ok;
  logic [7:0] ar_idx;

  function automatic logic fn_writable(input logic [7:0] idx);
    return idx >= IDX_MASTER && idx <= IDX_CTRL3;
  endfunction

  function automatic logic fn_upper_ok(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:10] == '0;
  endfunction

  assign e1 = q.mmode[MM_E1]; // [RULE_08]
  assign live = q.run & q.mmode[MM_FRAMER_ENABLE_BIT] & ~q.mmode[MM_SRST]; // [RULE_03] [RULE_07]
  assign s_axi_awready = ~q.aw_hold & ~q.bvalid;
  assign s_axi_wready = ~q.w_hold & ~q.bvalid;
  assign s_axi_arready = ~q.rvalid;
  assign aw_go = s_axi_awvalid & s_axi_awready;
  assign w_go = s_axi_wvalid & s_axi_wready;
  assign ar_go = s_axi_arvalid & s_axi_arready;
  assign ar_idx = s_axi_araddr[9:2];
  assign ar_ok = fn_upper_ok(s_axi_araddr) & (fn_writable(ar_idx) | ar_idx == IDX_SA6);
  // Only the low byte lane carries register data
  assign manual = q.ctl1[C1_REALIGN] & ~q.realign_prev; // [RULE_16]
  // E1 has no criterion bit: besides a realign edge, only loss of frame restarts the search there
  assign oof_ev = e1 ? q.e1_oof : (t1_oof_i & ~q.oof_prev);
  assign los_ev = line.los & ~q.los_prev;

  always_comb begin
    n = q;
    wr_ok = 1'b0;
    n.lclk_s = {q.lclk_s[1:0], rx_line_clk_i};
    n.pos_s = {q.pos_s[0], receive_line_positive_i};
    n.neg_s = {q.neg_s[0], receive_line_negative_i};
    // Write path: address and data may arrive in either order
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (aw_go) begin
      n.aw_hold = 1'b1;
      n.aw_idx = s_axi_awaddr[9:2];
      n.aw_ok = fn_upper_ok(s_axi_awaddr);
    end
    if (w_go) begin
      n.w_hold = 1'b1;
      n.w_byte = s_axi_wdata[7:0];
      n.w_en = s_axi_wstrb[0];
    end
    if (n.aw_hold && n.w_hold) begin
      n.aw_hold = 1'b0;
      n.w_hold = 1'b0;
      n.bvalid = 1'b1;
      wr_ok = n.aw_ok & fn_writable(n.aw_idx);
      n.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (wr_ok && n.w_en) begin
        unique case (n.aw_idx)
          IDX_MASTER: n.mmode = n.w_byte & MASK_MASTER;
          IDX_CTRL1: n.ctl1 = n.w_byte;
          IDX_CTRL2: n.ctl2 = n.w_byte;
          IDX_CTRL3: n.ctl3 = n.w_byte & MASK_CTRL3;
          default: ;
        endcase
      end
    end
    // Read path: answer one cycle after the address is taken
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (ar_go) begin
      n.rvalid = 1'b1;
      n.rresp = ar_ok ? RESP_OKAY : RESP_SLVERR;
      n.rbyte = 8'h00;
      if (ar_ok) begin
        unique case (ar_idx)
          IDX_MASTER: n.rbyte = q.mmode;
          IDX_CTRL1: n.rbyte = e1 ? (q.ctl1 & MASK_CTRL1_E1) : q.ctl1;
          IDX_CTRL2: n.rbyte = q.ctl2 & (e1 ? MASK_CTRL2_E1 : MASK_CTRL2_T1);
          IDX_CTRL3: n.rbyte = q.ctl3;
          IDX_SA6: n.rbyte = {4'h0, line.sa6_pat}; // [RULE_01]
          default: ;
        endcase
      end
    end
    // Start only on the completion edge, and only if enabled then
    n.init_prev = q.mmode[MM_INIT];
    if (!q.mmode[MM_FRAMER_ENABLE_BIT] || !q.mmode[MM_INIT]) begin
      n.run = 1'b0; // [RULE_03]
    end else if (!q.init_prev) begin
      n.run = 1'b1; // [RULE_06]
    end
    // Consecutive errored alignment words
    n.e1_oof = 1'b0;
    if (!live || !e1) begin
      n.fas_errs = '0;
    end else if ((fas_check_i && !fas_ok_i) ||
                 (q.ctl1[C1_FRC] && nfas_check_i && !nfas_bit2_ok_i)) begin // [RULE_20]
      if (q.fas_errs == FAS_ERR_LAST) begin
        n.fas_errs = '0;
        n.e1_oof = 1'b1;
      end else begin
        n.fas_errs = q.fas_errs + 2'h1;
      end
    end else if (fas_check_i || (q.ctl1[C1_FRC] && nfas_check_i)) begin
      n.fas_errs = '0;
    end
    // Resynchronisation requests
    n.realign_prev = q.ctl1[C1_REALIGN];
    n.oof_prev = t1_oof_i;
    n.los_prev = line.los;
    n.resync = live & (manual | (~q.ctl1[C1_NOAUTO] & // [RULE_15] [RULE_16]
               (oof_ev | (~e1 & ~q.ctl1[C1_ARC] & los_ev)))); // [RULE_12]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Line monitor hookup; pins are read only after two flip-flops
  assign line.live = live;
  assign line.bit_en = live & q.lclk_s[1] & ~q.lclk_s[2];
  assign line.pos = q.pos_s[1];
  assign line.neg = q.neg_s[1];
  assign line.nrz = q.ctl3[C3_IDF];
  assign line.e1 = e1;
  assign line.los_long = e1 & q.ctl2[C2_LOSA]; // [RULE_23]
  assign line.nfas = rx_nfas_frame_i;
  assign line.ts = rx_timeslot_i;
  assign line.bitpos = rx_bitpos_i;
  assign line.sa_sel = e1 ? q.ctl2[C2_SA_LSB +: 5] : 5'h00; // [RULE_22]

  rfc_line_mon u_mon (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .line(line.mon)
  );

  // Bus outputs
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = {24'h000000, q.rbyte};
  assign s_axi_rresp = q.rresp;

  // Decoded controls; T1 fields except the sync qualify length read zero in E1 mode and the reverse
  assign framer_active_o = q.run & q.mmode[MM_FRAMER_ENABLE_BIT]; // [RULE_03]
  assign receiver_reset_o = q.mmode[MM_SRST]; // [RULE_07]
  assign resync_o = q.resync;
  assign e1_mode_o = e1; // [RULE_08]
  assign t1_sync_qual_bits_o = q.ctl1[C1_SYNC_QUALIFY_LENGTH] ? SYNC_QUAL_LONG : SYNC_QUAL_SHORT; // [RULE_09]
  assign t1_zero_subst_decode_o = ~e1 & q.ctl1[C1_ZSUB]; // [RULE_10]
  assign e1_zero_subst_decode_o = e1 & q.ctl1[C1_ZSUB]; // [RULE_10]
  assign t1_d4_framing_o = ~e1 & q.ctl1[C1_FMT]; // [RULE_11]
  assign t1_resync_oof_only_o = ~e1 & q.ctl1[C1_ARC]; // [RULE_12]
  assign t1_d4_cross_couple_o = ~e1 & q.ctl1[C1_FMT] & q.ctl1[C1_SRCH]; // [RULE_13]
  assign t1_esf_crc_verify_o = ~e1 & ~q.ctl1[C1_FMT] & q.ctl1[C1_SRCH]; // [RULE_13]
  assign t1_japanese_crc_o = ~e1 & q.ctl1[C1_JCRC]; // [RULE_14]
  assign e1_ccs_signaling_o = e1 & q.ctl1[C1_SIGM]; // [RULE_17]
  assign e1_checksum_enable_o = e1 & q.ctl1[C1_CRC4]; // [RULE_19]
  // Code 7 gives 8; the 16-bit pattern repeats the 8-bit one
  assign loop_up_len_o = e1 ? 4'h0 : fn_code_len(q.ctl2[C2_UP_LSB +: 3]); // [RULE_21]
  assign loop_down_len_o = e1 ? 4'h0 : fn_code_len(q.ctl2[C2_DN_LSB +: 3]); // [RULE_21]
  assign los_o = line.los;
  assign bpv_count_enable_o = live & ~q.ctl3[C3_IDF]; // [RULE_24]
  assign line_bit_o = line.data;
  assign line_bit_en_o = line.data_en;
  assign receive_spare_bit_clock_o = line.spare_clk; // [RULE_22]
  assign receive_channel_block_o = channel_block_i | (e1 & q.ctl1[C1_TS26] &
         rx_timeslot_i == TS_G802 & rx_bitpos_i == BIT_FIRST); // [RULE_18]

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_idle;
    !q.mmode[MM_FRAMER_ENABLE_BIT] |-> !framer_active_o && !bpv_count_enable_o && !resync_o ##1 !resync_o;
  endproperty
  a_idle: assert property (p_idle) else $error("framer active while disabled"); // [RULE_03]

  property p_start;
    $rose(q.mmode[MM_INIT]) && q.mmode[MM_FRAMER_ENABLE_BIT] |=> framer_active_o;
  endproperty
  a_start: assert property (p_start) else $error("framer did not start on completion"); // [RULE_06]

  property p_srst;
    q.mmode[MM_SRST] |-> receiver_reset_o && !line.bit_en;
  endproperty
  a_srst: assert property (p_srst) else $error("receiver runs during soft reset"); // [RULE_07]

  property p_qual;
    !q.ctl1[C1_SYNC_QUALIFY_LENGTH] |-> t1_sync_qual_bits_o == 5'h0a;
  endproperty
  a_qual: assert property (p_qual) else $error("wrong sync qualify length"); // [RULE_09]

  property p_zsub;
    e1_mode_o |-> !t1_zero_subst_decode_o && !t1_d4_framing_o && !t1_japanese_crc_o;
  endproperty
  a_zsub: assert property (p_zsub) else $error("T1 control active in E1 mode"); // [RULE_10]

  property p_realign;
    live && $rose(q.ctl1[C1_REALIGN]) |=> resync_o;
  endproperty
  a_realign: assert property (p_realign) else $error("realign edge gave no resync"); // [RULE_16]

  property p_noauto;
    q.ctl1[C1_NOAUTO] && !manual |=> !resync_o;
  endproperty
  a_noauto: assert property (p_noauto) else $error("automatic resync while disabled"); // [RULE_15]

  property p_fas3;
    live && e1 && q.fas_errs == 2'h2 && fas_check_i && !fas_ok_i && !q.ctl1[C1_NOAUTO] |=> ##1 resync_o;
  endproperty
  a_fas3: assert property (p_fas3) else $error("no resync after three bad words"); // [RULE_20]

  property p_ts26;
    e1 && q.ctl1[C1_TS26] && rx_timeslot_i == 5'h1a && rx_bitpos_i == 3'h0 |-> receive_channel_block_o;
  endproperty
  a_ts26: assert property (p_ts26) else $error("slot 26 not blocked"); // [RULE_18]

  property p_len;
    !e1 && q.ctl2[5:3] == 3'h7 |-> loop_up_len_o == 4'h8;
  endproperty
  a_len: assert property (p_len) else $error("loop-up length wrong"); // [RULE_21]

  property p_sa6;
    ar_go && ar_idx == IDX_SA6 && fn_upper_ok(s_axi_araddr) |=> s_axi_rvalid && s_axi_rdata[31:4] == 28'h0;
  endproperty
  a_sa6: assert property (p_sa6) else $error("Sa6 read carries upper bits"); // [RULE_01]

  property p_nrz;
    q.ctl3[C3_IDF] |-> !bpv_count_enable_o;
  endproperty
  a_nrz: assert property (p_nrz) else $error("BPV counting in NRZ mode"); // [RULE_24]

  c_start: cover property ($rose(framer_active_o));
  c_resync: cover property (live && manual ##1 resync_o);
  c_e1_oof: cover property ($rose(q.e1_oof));
endmodule // rfc_rx_framer_ctl
`default_nettype wire

// ==== testbench/rfc_line_src.sv ====
// Purpose: Incoming line model, one bipolar bit per call
// Assumes: Line clock pulse of 3 clk high and 3 clk low
// Notes: Clock stands still between calls; both data lines hold their inverted values then
`timescale 1ns/1ps
`default_nettype none
module rfc_line_src (
  // Clock
  input wire logic clk_i,
  // Line pins
  output logic lclk_o,
  output logic pos_o,
  output logic neg_o
);
  logic mark_neg = 1'b0;
  initial begin
    lclk_o = 1'b0;
    pos_o = 1'b0;
    neg_o = 1'b1;
  end
  // Marks alternate polarity, spaces are both lines low
  task automatic send(input logic b);
    @(posedge clk_i);
    pos_o <= b & ~mark_neg;
    neg_o <= b & mark_neg;
    mark_neg <= mark_neg ^ b;
    repeat (2) @(posedge clk_i);
    lclk_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    lclk_o <= 1'b0;
    pos_o <= ~pos_o;
    neg_o <= ~neg_o;
  endtask
endmodule // rfc_line_src
`default_nettype wire

// ==== testbench/tb_rfc_rx_framer_ctl.sv ====
// Purpose: Self-checking bench for the receive framer control block
// Assumes: Register index n at byte address 4*n
// Notes: Core position and word checks are driven here, line bits by the model
`timescale 1ns/1ps
`default_nettype none
module tb_rfc_rx_framer_ctl;
  import rfc_pkg::*;
  logic clk_i, rst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, loop_up_len_o, loop_down_len_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic rx_line_clk_i, receive_line_positive_i, receive_line_negative_i;
  logic [4:0] rx_timeslot_i, t1_sync_qual_bits_o;
  logic [2:0] rx_bitpos_i;
  logic rx_nfas_frame_i, t1_oof_i, fas_check_i, fas_ok_i, nfas_check_i, nfas_bit2_ok_i, channel_block_i;
  logic framer_active_o, receiver_reset_o, resync_o, e1_mode_o, t1_zero_subst_decode_o, e1_zero_subst_decode_o;
  logic t1_d4_framing_o, t1_resync_oof_only_o, t1_d4_cross_couple_o, t1_esf_crc_verify_o, t1_japanese_crc_o;
  logic e1_ccs_signaling_o, e1_checksum_enable_o, los_o, bpv_count_enable_o, line_bit_o, line_bit_en_o;
  logic receive_spare_bit_clock_o, receive_channel_block_o;
  int fail_count = 0;
  int n_checks = 0;
  int n_resync = 0;

  rfc_rx_framer_ctl #(.ADDR_W(12)) uut (.*);
  rfc_line_src src (.clk_i(clk_i), .lclk_o(rx_line_clk_i), .pos_o(receive_line_positive_i),
    .neg_o(receive_line_negative_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (resync_o === 1'b1) n_resync++;

  task automatic summarize;
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic lim(input int n);
    if (n >= 50) begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Handshakes are judged from values sampled half a cycle before the edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic ra, rw, rb;
    logic [1:0] r;
    int n;
    @(posedge clk_i);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clk_i);
      ra = s_axi_awready;
      rw = s_axi_wready;
      rb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_i);
      if (ra) s_axi_awvalid <= 1'b0;
      if (rw) s_axi_wvalid <= 1'b0;
      if (rb) break;
    end
    s_axi_bready <= 1'b0;
    lim(n);
    chk(r, er);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er);
    logic ra, rb;
    logic [31:0] dd;
    logic [1:0] r;
    int n;
    @(posedge clk_i);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clk_i);
      ra = s_axi_arready;
      rb = s_axi_rvalid;
      dd = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_i);
      if (ra) s_axi_arvalid <= 1'b0;
      if (rb) break;
    end
    s_axi_rready <= 1'b0;
    lim(n);
    chk(dd, {24'h0, ed});
    chk(r, er);
  endtask
  task automatic pos(input logic [4:0] t, input logic [2:0] b, input logic nf);
    @(posedge clk_i);
    rx_timeslot_i <= t;
    rx_bitpos_i <= b;
    rx_nfas_frame_i <= nf;
    w(3);
  endtask
  task automatic word(input logic nf, input logic ok);
    @(posedge clk_i);
    fas_check_i <= ~nf;
    nfas_check_i <= nf;
    fas_ok_i <= ok;
    nfas_bit2_ok_i <= ok;
    @(posedge clk_i);
    fas_check_i <= 1'b0;
    nfas_check_i <= 1'b0;
    w(3);
  endtask

  task automatic t_reset;
    rdc(IDX_MASTER, 8'h00, RESP_OKAY);
    s_axi_wstrb <= 4'he;
    wr(IDX_CTRL2, 8'hff, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rdc(IDX_CTRL2, 8'h00, RESP_OKAY);
    rdc(IDX_SA6, 8'h00, RESP_OKAY);
    chk({t1_sync_qual_bits_o, loop_up_len_o, loop_down_len_o, framer_active_o}, {5'h0a, 4'h1, 4'h1, 1'b0});
    wr(8'h84, 8'h55, RESP_SLVERR);
    rdc(8'h84, 8'h00, RESP_SLVERR);
    wr(IDX_SA6, 8'hff, RESP_SLVERR);
  endtask
  // T1 decodes, every bit but search and realign flipped between two settings
  task automatic t_t1;
    wr(IDX_CTRL1, 8'hfe, RESP_OKAY);
    rdc(IDX_CTRL1, 8'hfe, RESP_OKAY);
    chk({t1_sync_qual_bits_o, t1_zero_subst_decode_o, t1_d4_framing_o, t1_resync_oof_only_o, t1_d4_cross_couple_o,
      t1_esf_crc_verify_o, t1_japanese_crc_o}, {5'h18, 6'b111101});
    wr(IDX_CTRL1, 8'h08, RESP_OKAY);
    w(1);
    chk({t1_sync_qual_bits_o, t1_zero_subst_decode_o, t1_d4_framing_o, t1_resync_oof_only_o, t1_d4_cross_couple_o,
      t1_esf_crc_verify_o, t1_japanese_crc_o}, {5'h0a, 6'b000010});
    wr(IDX_CTRL2, 8'h3e, RESP_OKAY);
    w(1);
    chk({loop_up_len_o, loop_down_len_o}, {4'h8, 4'h7});
    wr(IDX_CTRL3, 8'h80, RESP_OKAY);
  endtask
  // Host programs enable and standard first, then completion
  task automatic t_e1_init;
    wr(IDX_MASTER, 8'h81, RESP_OKAY);
    wr(IDX_CTRL1, 8'hbc, RESP_OKAY);
    rdc(IDX_CTRL1, 8'h3c, RESP_OKAY);
    rdc(IDX_CTRL2, 8'h38, RESP_OKAY);
    chk({framer_active_o, e1_mode_o, e1_zero_subst_decode_o, e1_ccs_signaling_o, e1_checksum_enable_o,
      t1_d4_framing_o, loop_up_len_o}, {6'b010110, 4'h0});
    wr(IDX_MASTER, 8'hc1, RESP_OKAY);
    w(3);
    chk({framer_active_o, bpv_count_enable_o}, 2'b10);
    wr(IDX_CTRL3, 8'h00, RESP_OKAY);
    w(1);
    chk(bpv_count_enable_o, 1'b1);
    pos(5'd26, 3'd0, 1'b0);
    chk(receive_channel_block_o, 1'b1);
    pos(5'd26, 3'd1, 1'b0);
    chk(receive_channel_block_o, 1'b0);
    @(posedge clk_i);
    channel_block_i <= 1'b1;
    w(1);
    chk(receive_channel_block_o, 1'b1);
  endtask
  task automatic t_resync;
    int base;
    base = n_resync;
    wr(IDX_CTRL1, 8'h3d, RESP_OKAY);
    wr(IDX_CTRL1, 8'h3d, RESP_OKAY);
    w(4);
    chk(n_resync, base + 1);
    word(0, 0);
    word(1, 0);
    word(0, 1);
    word(0, 0);
    word(1, 0);
    chk(n_resync, base + 1);
    word(0, 0);
    chk(n_resync, base + 2);
    wr(IDX_CTRL1, 8'h3e, RESP_OKAY);
    repeat (3) word(0, 0);
    chk(n_resync, base + 2);
  endtask
  // LOS at exactly 255 zeros, then Sa6 capture and spare-bit clock gating
  task automatic t_line;
    repeat (254) src.send(1'b0);
    w(8);
    chk(los_o, 1'b0);
    src.send(1'b0);
    w(8);
    chk(los_o, 1'b1);
    src.send(1'b1);
    w(8);
    chk({los_o, line_bit_o}, 2'b01);
    pos(5'd0, 3'd7, 1'b1);
    chk(receive_spare_bit_clock_o, 1'b0);
    pos(5'd0, SA6_BIT, 1'b1);
    chk(receive_spare_bit_clock_o, 1'b1);
    src.send(1'b1);
    src.send(1'b0);
    src.send(1'b1);
    src.send(1'b0);
    w(8);
    rdc(IDX_SA6, 8'h0a, RESP_OKAY);
  endtask
  task automatic t_ctrl_off;
    int base;
    base = n_resync;
    wr(IDX_MASTER, 8'hc3, RESP_OKAY);
    w(1);
    chk(receiver_reset_o, 1'b1);
    wr(IDX_CTRL1, 8'h3f, RESP_OKAY);
    w(4);
    chk(n_resync, base);
    wr(IDX_MASTER, 8'hc1, RESP_OKAY);
    rdc(IDX_MASTER, 8'hc1, RESP_OKAY);
    wr(IDX_MASTER, 8'h41, RESP_OKAY);
    w(3);
    chk({receiver_reset_o, framer_active_o}, 2'b00);
    wr(IDX_MASTER, 8'h80, RESP_OKAY);
    wr(IDX_MASTER, 8'hc0, RESP_OKAY);
    wr(IDX_CTRL1, 8'h10, RESP_OKAY);
    t1_oof_i <= 1'b1;
    w(4);
    chk(n_resync, base + 1);
  endtask

  initial begin
    rst_i = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, rx_bitpos_i, rx_nfas_frame_i, t1_oof_i, fas_check_i, fas_ok_i, nfas_check_i} = '0;
    {nfas_bit2_ok_i, channel_block_i} = '0;
    s_axi_wstrb = 4'hf;
    rx_timeslot_i = 5'h01;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    w(1);
    t_reset();
    t_t1();
    t_e1_init();
    t_resync();
    t_line();
    t_ctrl_off();
    summarize();
  end
endmodule // tb_rfc_rx_framer_ctl
`default_nettype wire
